// ---- verilog/swp_defs.vh ----
// Constants shared by the serial wire debug port.
`ifndef SWP_DEFS_VH
`define SWP_DEFS_VH
// Acknowledge codes, sent least significant bit first.
`define ACK_OK 3'h1
`define ACK_WAIT 3'h2
`define ACK_FAULT 3'h4
// Link bit counts.
`define LINE_RESET_ONES 6'h32
`define REQ_LAST 6'h07
`define ACK_LAST 6'h02
`define DATA_LAST 6'h20
// Debug port register addresses, request bits A[3:2].
`define REG_IDENT 2'h0
`define REG_ABORT 2'h0
`define REG_CTRL_STAT 2'h1
`define REG_SELECT 2'h2
`define REG_RESEND 2'h2
`define REG_READ_BUFFER 2'h3
// Control/status fields.
`define CS_ORUN_DETECT 0
`define CS_STICKY_ORUN 1
`define CS_STICKY_CMP 4
`define CS_STICKY_ERR 5
`define CS_READ_OK 6
`define CS_WR_DATA_ERR 7
// Abort register fields.
`define AB_ABORT 0
`define AB_CMP_CLR 1
`define AB_ERR_CLR 2
`define AB_WDERR_CLR 3
`define AB_ORUN_CLR 4
// Select register bank field.
`define SEL_BANK_HI 7
`define SEL_BANK_LO 4
// Bus-side registers.
`define APB_MODE 8'h00
`define APB_STATUS 8'h04
`define MODE_PUSHED 0
`define MODE_WBUF 1
`define MODE_RESET 2'h0
`define ST_BUSY 8
`define ST_WBUF 9
`define ST_LOST 10
`endif

// ---- verilog/serial_wire_port.v ----
// Serial wire debug port: request decode, acknowledge choice and recovery.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

// How it works
// (R1) Identification read, control/status read and abort write are never answered WAIT.
// (R2) Other requests get WAIT while an earlier access is outstanding, except buffered access port writes while the buffer is empty.
// (R3) An access port read waits until the previous read result exists.
// (R4) Host retries the same request after WAIT, or writes abort eventually.
// (R5) Abort frees the system-side interface at once, via an abort pulse.
// (R6) The three exempt accesses are never answered FAULT.
// (R7) Any other access gets FAULT while a sticky flag is set.
// (R8) Abort register bits clear the matching sticky flags.
// (R9) Request during a pending transaction gets WAIT, and sets overrun if enabled.
// (R10) With overrun detection on, WAIT and FAULT keep a full data phase.
// (R11) That read data phase leaves the line undriven.
// (R12) That write data phase is ignored.
// (R13) A request parity error gets no acknowledge; the line stays undriven.
// (R14) After no acknowledge the host backs off, then reads identification.
// (R15) A second silence makes the host line-reset and read identification.
// (R16) After losing frame sync the port answers only a line reset.
// (R17) With buffering, OK to a write means accepted, not completed.
// (R18) Accesses run in order; debug port writes other than abort stall behind buffered writes.
// (R19) An abandoned buffered write sets the write data error flag.
// (R20) Sticky set, abort write, or exempt read abandons buffered writes.
// (R21) Access port reads and non-exempt debug accesses wait for an empty buffer.
// (R22) Pushed mode turns access port writes into compared reads.
// (R23) Host flushes buffered writes with a stallable access before exempt ones.
// (R24) Fifty consecutive ones are a line reset in any state.
// (R25) OK is encoded 001.
// (R26) Every field goes least significant bit first.
// (R27) WAIT is 010 and FAULT is 100.
module serial_wire_port #(
    // Identification value is arbitrary.
    parameter [31:0] ID_VALUE = 32'h1234ABCD
) (
    input wire clk,
    input wire rst_n,
    input wire swclk,
    input wire swdio_in,
    output reg swdio_out,
    output reg swdio_oe,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg sys_req,
    output reg sys_wr,
    output reg [5:0] sys_addr,
    output reg [31:0] sys_wdata,
    output reg sys_abort,
    input wire sys_ack,
    input wire [31:0] sys_rdata,
    input wire sys_err
);

    // =====================================================================
    // States
    localparam [7:0] S_LOST = 8'h01;
    localparam [7:0] S_IDLE = 8'h02;
    localparam [7:0] S_REQ = 8'h04;
    localparam [7:0] S_TRN1 = 8'h08;
    localparam [7:0] S_ACK = 8'h10;
    localparam [7:0] S_RD = 8'h20;
    localparam [7:0] S_TRN2 = 8'h40;
    localparam [7:0] S_WR = 8'h80;

    reg [2:0] clk_sync_q;
    reg [1:0] dio_sync_q;
    reg [7:0] state_q;
    reg [5:0] cnt_q;
    reg [5:0] ones_q;
    reg need_zero_q;
    reg [7:0] rq_q;
    reg [32:0] sh_q;
    reg [2:0] ack_q;
    reg [2:0] ack_sh_q;
    reg rd_q;
    reg is_acc_q;
    reg [1:0] addr_q;
    reg dph_q;
    reg nxt_bit_q;
    reg nxt_oe_q;
    reg [1:0] mode_q;
    reg orun_en_q;
    reg sticky_orun_q;
    reg sticky_cmp_q;
    reg sticky_err_q;
    reg wr_data_err_q;
    reg read_ok_q;
    reg [31:0] select_q;
    reg [31:0] last_rd_q;
    reg [31:0] sys_res_q;
    reg cmp_q;
    reg [31:0] cmp_data_q;
    reg wb_valid_q;
    reg [5:0] wb_addr_q;
    reg [31:0] wb_data_q;

    // =====================================================================
    // Link sampling
    // The link clock is slow against clk, so its edges are found after
    // synchronising; data and clock pass the same two stages.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_sync_q <= 3'h0;
            dio_sync_q <= 2'h0;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], swclk};
            dio_sync_q <= {dio_sync_q[0], swdio_in};
        end
    end

    wire rise = clk_sync_q[1] & ~clk_sync_q[2];
    wire fall = ~clk_sync_q[1] & clk_sync_q[2];
    wire bit_in = dio_sync_q[1];

    // =====================================================================
    // Request decode
    wire [7:0] req_w = {bit_in, rq_q[7:1]};
    wire req_acc = req_w[1];
    wire req_rd = req_w[2];
    wire [1:0] req_a = req_w[4:3];
    wire req_bad = ((^req_w[4:1]) != req_w[5]) | req_w[6] | ~req_w[7];
    wire pushed = mode_q[`MODE_PUSHED];
    wire wbuf_en = mode_q[`MODE_WBUF];
    wire sticky_any = sticky_orun_q | sticky_cmp_q | sticky_err_q | wr_data_err_q;
    wire busy = sys_req | wb_valid_q;
    wire exempt_rd = ~req_acc & req_rd & ((req_a == `REG_IDENT) | (req_a == `REG_CTRL_STAT));
    wire exempt_wr = ~req_acc & ~req_rd & (req_a == `REG_ABORT);
    wire exempt = exempt_rd | exempt_wr;
    wire acc_buf_wr = req_acc & ~req_rd & ~pushed & wbuf_en;
    wire stall = acc_buf_wr ? wb_valid_q : busy; // R2 R3 R18 R21
    wire sticky_rd = req_rd & (req_acc | (req_a == `REG_READ_BUFFER));

    reg [2:0] ack_w;
    reg [31:0] rd_val;
    reg [31:0] cs_w;

    always @*
    begin
        cs_w = 32'h0;
        cs_w[`CS_ORUN_DETECT] = orun_en_q;
        cs_w[`CS_STICKY_ORUN] = sticky_orun_q;
        cs_w[`CS_STICKY_CMP] = sticky_cmp_q;
        cs_w[`CS_STICKY_ERR] = sticky_err_q;
        cs_w[`CS_READ_OK] = read_ok_q;
        cs_w[`CS_WR_DATA_ERR] = wr_data_err_q;
        if (exempt)
            ack_w = `ACK_OK; // R1 R6 R25
        else if (sticky_any)
            ack_w = `ACK_FAULT; // R7 R27
        else if (stall)
            ack_w = `ACK_WAIT; // R27
        else
            ack_w = `ACK_OK;
        if (req_acc)
            rd_val = sys_res_q;
        else
        begin
            case (req_a)
                `REG_IDENT: rd_val = ID_VALUE;
                `REG_CTRL_STAT: rd_val = cs_w;
                `REG_RESEND: rd_val = last_rd_q;
                default: rd_val = sys_res_q;
            endcase
        end
    end

    wire [32:0] wd_w = {bit_in, sh_q[32:1]};
    wire wd_par_ok = (^wd_w[31:0]) == wd_w[32];
    wire ok_q = (ack_q == `ACK_OK);

    // =====================================================================
    // Protocol engine and system-side access
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_LOST;
            cnt_q <= 6'h0;
            ones_q <= 6'h0;
            need_zero_q <= 1'b1;
            rq_q <= 8'h0;
            sh_q <= 33'h0;
            ack_q <= 3'h0;
            ack_sh_q <= 3'h0;
            rd_q <= 1'b0;
            is_acc_q <= 1'b0;
            addr_q <= 2'h0;
            dph_q <= 1'b0;
            nxt_bit_q <= 1'b0;
            nxt_oe_q <= 1'b0;
            swdio_out <= 1'b0;
            swdio_oe <= 1'b0;
            orun_en_q <= 1'b0;
            sticky_orun_q <= 1'b0;
            sticky_cmp_q <= 1'b0;
            sticky_err_q <= 1'b0;
            wr_data_err_q <= 1'b0;
            read_ok_q <= 1'b0;
            select_q <= 32'h0;
            last_rd_q <= 32'h0;
            sys_res_q <= 32'h0;
            cmp_q <= 1'b0;
            cmp_data_q <= 32'h0;
            wb_valid_q <= 1'b0;
            wb_addr_q <= 6'h0;
            wb_data_q <= 32'h0;
            sys_req <= 1'b0;
            sys_wr <= 1'b0;
            sys_addr <= 6'h0;
            sys_wdata <= 32'h0;
            sys_abort <= 1'b0;
        end
        else
        begin
            sys_abort <= 1'b0;
            if (fall)
            begin
                swdio_out <= nxt_bit_q;
                swdio_oe <= nxt_oe_q;
            end
            // System side completion; errors and compare misses set flags.
            if (sys_req & sys_ack)
            begin
                sys_req <= 1'b0;
                if (!sys_wr)
                    sys_res_q <= sys_rdata;
                if (sys_err)
                    sticky_err_q <= 1'b1;
                if (cmp_q & (sys_rdata != cmp_data_q))
                    sticky_cmp_q <= 1'b1;
                cmp_q <= 1'b0;
            end
            if (wb_valid_q & sticky_any)
            begin
                wb_valid_q <= 1'b0; // R20
                wr_data_err_q <= 1'b1; // R19
            end
            else if (wb_valid_q & ~sys_req)
            begin
                // Buffered writes drain strictly in arrival order.
                wb_valid_q <= 1'b0; // R18
                sys_req <= 1'b1;
                sys_wr <= 1'b1;
                sys_addr <= wb_addr_q;
                sys_wdata <= wb_data_q;
            end
            if (rise)
            begin
                need_zero_q <= need_zero_q & bit_in;
                case (state_q)
                    S_LOST:
                    begin
                        nxt_oe_q <= 1'b0; // R16
                    end
                    S_IDLE:
                    begin
                        if (bit_in & ~need_zero_q)
                        begin
                            state_q <= S_REQ;
                            cnt_q <= 6'h1;
                            rq_q <= req_w;
                        end
                    end
                    S_REQ:
                    begin
                        rq_q <= req_w; // R26
                        cnt_q <= cnt_q + 6'h1;
                        if (cnt_q == `REQ_LAST)
                        begin
                            if (req_bad)
                                state_q <= S_LOST; // R13
                            else
                            begin
                                state_q <= S_TRN1;
                                ack_q <= ack_w;
                                ack_sh_q <= ack_w;
                                rd_q <= req_rd;
                                is_acc_q <= req_acc;
                                addr_q <= req_a;
                                dph_q <= (ack_w == `ACK_OK) | orun_en_q; // R10
                                if ((ack_w == `ACK_WAIT) & orun_en_q)
                                    sticky_orun_q <= 1'b1; // R9
                                if (sticky_rd)
                                    read_ok_q <= (ack_w == `ACK_OK);
                                if (exempt & wb_valid_q)
                                begin
                                    wb_valid_q <= 1'b0; // R20
                                    wr_data_err_q <= 1'b1; // R19
                                end
                                if ((ack_w == `ACK_OK) & req_rd)
                                begin
                                    sh_q <= {^rd_val, rd_val};
                                    if (sticky_rd | (req_a == `REG_RESEND))
                                        last_rd_q <= rd_val;
                                    if (req_acc)
                                    begin
                                        // Posted read: this one returns the previous result.
                                        sys_req <= 1'b1; // R3
                                        sys_wr <= 1'b0;
                                        sys_addr <= {select_q[`SEL_BANK_HI:`SEL_BANK_LO], req_a};
                                    end
                                end
                            end
                        end
                    end
                    S_TRN1:
                    begin
                        state_q <= S_ACK;
                        cnt_q <= 6'h0;
                        nxt_bit_q <= ack_sh_q[0]; // R26
                        ack_sh_q <= {1'b0, ack_sh_q[2:1]};
                        nxt_oe_q <= 1'b1;
                    end
                    S_ACK:
                    begin
                        cnt_q <= cnt_q + 6'h1;
                        nxt_bit_q <= ack_sh_q[0];
                        ack_sh_q <= {1'b0, ack_sh_q[2:1]};
                        if (cnt_q == `ACK_LAST)
                        begin
                            cnt_q <= 6'h0;
                            if (rd_q & dph_q)
                            begin
                                state_q <= S_RD;
                                nxt_bit_q <= sh_q[0];
                                nxt_oe_q <= ok_q; // R11
                            end
                            else
                            begin
                                state_q <= S_TRN2;
                                nxt_oe_q <= 1'b0;
                            end
                        end
                    end
                    S_RD:
                    begin
                        cnt_q <= cnt_q + 6'h1;
                        sh_q <= {1'b0, sh_q[32:1]};
                        nxt_bit_q <= sh_q[1];
                        if (cnt_q == `DATA_LAST)
                        begin
                            state_q <= S_TRN2;
                            nxt_oe_q <= 1'b0;
                        end
                    end
                    S_TRN2:
                    begin
                        cnt_q <= 6'h0;
                        state_q <= (~rd_q & dph_q) ? S_WR : S_IDLE;
                    end
                    S_WR:
                    begin
                        cnt_q <= cnt_q + 6'h1;
                        sh_q <= wd_w;
                        if (cnt_q == `DATA_LAST)
                        begin
                            state_q <= S_IDLE;
                            if (ok_q & ~wd_par_ok) // R12
                                wr_data_err_q <= 1'b1;
                            else if (ok_q & is_acc_q & mode_q[`MODE_PUSHED])
                            begin
                                sys_req <= 1'b1; // R22
                                sys_wr <= 1'b0;
                                sys_addr <= {select_q[`SEL_BANK_HI:`SEL_BANK_LO], addr_q};
                                cmp_q <= 1'b1;
                                cmp_data_q <= wd_w[31:0];
                            end
                            else if (ok_q & is_acc_q & sys_req)
                            begin
                                // Accepted only; completion is not implied.
                                wb_valid_q <= 1'b1; // R17
                                wb_addr_q <= {select_q[`SEL_BANK_HI:`SEL_BANK_LO], addr_q};
                                wb_data_q <= wd_w[31:0];
                            end
                            else if (ok_q & is_acc_q)
                            begin
                                sys_req <= 1'b1;
                                sys_wr <= 1'b1;
                                sys_addr <= {select_q[`SEL_BANK_HI:`SEL_BANK_LO], addr_q};
                                sys_wdata <= wd_w[31:0];
                            end
                            else if (ok_q & (addr_q == `REG_CTRL_STAT))
                                orun_en_q <= wd_w[`CS_ORUN_DETECT];
                            else if (ok_q & (addr_q == `REG_SELECT))
                                select_q <= wd_w[31:0];
                            else if (ok_q & (addr_q == `REG_ABORT))
                            begin
                                // Compare clear is skipped when a compared read completes this cycle, error clear when an erroring access completes this cycle, so a set still lands.
                                if (wd_w[`AB_CMP_CLR] & ~(sys_req & sys_ack & cmp_q))
                                    sticky_cmp_q <= 1'b0; // R8
                                if (wd_w[`AB_ERR_CLR] & ~(sys_req & sys_ack & sys_err))
                                    sticky_err_q <= 1'b0; // R8
                                if (wd_w[`AB_WDERR_CLR])
                                    wr_data_err_q <= 1'b0; // R8
                                if (wd_w[`AB_ORUN_CLR])
                                    sticky_orun_q <= 1'b0; // R8
                                if (wd_w[`AB_ABORT])
                                begin
                                    sys_abort <= 1'b1; // R5
                                    sys_req <= 1'b0;
                                    cmp_q <= 1'b0;
                                end
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= S_LOST;
                    end
                endcase
                // Line reset overrides whatever the frame was doing.
                ones_q <= (bit_in & ~swdio_oe) ? ones_q + 6'h1 : 6'h0;
                if (bit_in & ~swdio_oe & (ones_q == `LINE_RESET_ONES - 6'h1))
                begin
                    ones_q <= 6'h0;
                    state_q <= S_IDLE; // R24
                    need_zero_q <= 1'b1;
                    nxt_oe_q <= 1'b0;
                end
            end
        end
    end

    // =====================================================================
    // Bus slave
    // Every access takes one wait state so that pready comes from a flop.
    wire apb_sel = psel & penable & ~pready;
    wire apb_hit = (paddr == `APB_MODE) | (paddr == `APB_STATUS);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            mode_q <= `MODE_RESET;
        end
        else
        begin
            pready <= apb_sel;
            pslverr <= apb_sel & ~apb_hit;
            prdata <= 32'h0;
            if (apb_sel & ~pwrite & (paddr == `APB_MODE))
                prdata <= {30'h0, mode_q};
            if (apb_sel & ~pwrite & (paddr == `APB_STATUS))
            begin
                prdata <= cs_w;
                prdata[`ST_BUSY] <= sys_req;
                prdata[`ST_WBUF] <= wb_valid_q;
                prdata[`ST_LOST] <= state_q[0];
            end
            if (psel & penable & pready & pwrite & (paddr == `APB_MODE))
                mode_q <= pwdata[1:0];
        end
    end

endmodule
`default_nettype wire

// ---- testbench/swp_props.sv ----
// Concurrent checks on the ports of the serial wire debug port.
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"
module swp_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic swclk,
    input wire logic swdio_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sys_req,
    input wire logic sys_wr,
    input wire logic [5:0] sys_addr,
    input wire logic sys_ack,
    input wire logic sys_abort
);
    // ==========
    // Drive span counter
    logic sck_q;
    logic [5:0] rises_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            sck_q <= 1'b0;
            rises_q <= 6'h00;
        end
        else
        begin
            sck_q <= swclk;
            rises_q <= !swdio_oe ? 6'h00 : rises_q + {5'h00, swclk && !sck_q};
        end
    // ==========
    // Assertions
    a_drive_span: assert property ($fell(swdio_oe) |-> rises_q inside {6'h03, 6'h24})
        else $error("bad drive span");
    a_abort_frees: assert property (sys_abort |-> !sys_req ##1 !sys_abort)
        else $error("abort did not free request");
    a_req_held: assert property (sys_req && !sys_ack |=>
        sys_abort || sys_req && $stable({sys_addr, sys_wr})) else $error("request changed");
    a_done_drops: assert property (sys_req && sys_ack && !sys_wr |=> !sys_req || sys_wr)
        else $error("request outlived ack");
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_decode: assert property (pready |-> pslverr == !(paddr inside {`APB_MODE, `APB_STATUS}))
        else $error("wrong error response");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access gave data");
    c_abort: cover property (sys_abort);
    c_read_span: cover property ($fell(swdio_oe) && rises_q == 6'h24);
    c_unmapped: cover property (pready && pslverr);
endmodule
bind serial_wire_port swp_props props (.clk, .rst_n, .swclk, .swdio_oe, .psel, .penable,
    .paddr, .prdata, .pready, .pslverr, .sys_req, .sys_wr, .sys_addr, .sys_ack, .sys_abort);
`default_nettype wire

// ---- testbench/debug_host.sv ----
// Debug host probe model driving the serial link.
`timescale 1ns/1ps
`default_nettype none
module debug_host (
    output logic swclk,
    output logic swdio_in,
    input wire logic swdio_out,
    input wire logic swdio_oe
);
    logic h_oe = 1'b1;
    logic h_bit = 1'b0;
    logic [2:0] ack;
    logic [32:0] rd;
    initial swclk = 1'b0;
    // A pull-up holds the line high whenever nobody drives it.
    assign swdio_in = swdio_oe ? swdio_out : (h_oe ? h_bit : 1'b1);
    task cyc(input logic d, input logic drv, output logic s);
        h_oe = drv;
        h_bit = d;
        #97 swclk = 1'b1;
        #95 s = swdio_in;
        #8 swclk = 1'b0;
    endtask
    task idle(input int n, input logic v);
        logic s;
        repeat (n) cyc(v, 1'b1, s);
    endtask
    task xfer(input logic acc, rnw, input logic [1:0] a, input logic bad,
        input logic [31:0] wd, input logic dph);
        logic [7:0] q;
        logic [32:0] w;
        logic s;
        q = {2'b10, ^{acc, rnw, a} ^ bad, a[1], a[0], rnw, acc, 1'b1};
        w = {^wd, wd};
        for (int i = 0; i < 8; i++) cyc(q[i], 1'b1, s);
        cyc(1'b0, 1'b0, s);
        for (int i = 0; i < 3; i++) cyc(1'b0, 1'b0, ack[i]);
        if (!rnw) cyc(1'b0, 1'b0, s);
        // Read parity goes unchecked: a refused read carries no data.
        if (ack == 3'h1 || (dph && ack != 3'h7))
            for (int i = 0; i < 33; i++) cyc(w[i], !rnw, rd[i]);
        if (rnw) cyc(1'b0, 1'b0, s);
        h_oe = 1'b1;
        h_bit = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench/serial_wire_port_test.sv ----
// Self-checking testbench for the serial wire debug port.
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"
module serial_wire_port_test;
    // Arbitrary identification value.
    localparam logic [31:0] ID = 32'h5A3C0F96;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sys_ack = 1'b0, sys_err = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, sys_rdata = 32'h0, prdata, sys_wdata;
    logic swclk, swdio_in, swdio_out, swdio_oe, pready, pslverr, sys_req, sys_wr, sys_abort;
    logic hold = 1'b0, odet = 1'b0, last_wr;
    logic [5:0] sys_addr;
    logic [34:0] seen;
    logic [66:0] x;
    logic [66:0] exp_q[$];
    int n_errors = 0, comparisons = 0, seed = 4644;
    event got;
    always #12.5 clk = ~clk;
    initial #2000000 results(1);
    serial_wire_port #(.ID_VALUE(ID)) dut (.clk, .rst_n, .swclk, .swdio_in, .swdio_out,
        .swdio_oe, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sys_req, .sys_wr, .sys_addr, .sys_wdata, .sys_abort, .sys_ack, .sys_rdata, .sys_err);
    debug_host hp (.swclk, .swdio_in, .swdio_out, .swdio_oe);
    // ==========
    // System side responder, stalled while hold is set
    always @(posedge clk)
    begin
        sys_ack <= sys_req && !sys_ack && !hold;
        sys_rdata <= $random(seed);
        if (sys_req && !sys_ack)
            last_wr <= sys_wr;
    end
    always @(got)
    begin
        x = exp_q.pop_front();
        comparisons++;
        if (seen[34:32] !== x[66:64] || (seen[31:0] & x[63:32]) !== x[31:0])
        begin
            n_errors++;
            $display("CHECK FAILED response: expected %h seen %h", x, seen);
        end
    end
    task post(input logic [34:0] v);
        seen = v;
        -> got;
        #1;
    endtask
    task tr(input logic acc, rnw, input logic [1:0] a, input logic bad, input logic [31:0] wd,
        input logic [2:0] ea, input logic [31:0] m, input logic [31:0] d);
        exp_q.push_back({ea, m, d & m});
        @(negedge clk);
        hp.xfer(acc, rnw, a, bad, wd, odet);
        post({hp.ack, hp.rd[31:0]});
    endtask
    task lreset;
        @(negedge clk);
        hp.idle(50, 1'b1);
        hp.idle(2, 1'b0);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee,
        input logic [31:0] m, input logic [31:0] ed);
        int k;
        exp_q.push_back({2'b00, ee, m, ed & m});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 9 && pready !== 1'b1; k++) @(posedge clk);
        if (k == 9) results(1);
        psel <= 1'b0;
        penable <= 1'b0;
        post({2'b00, pslverr, prdata});
    endtask
    task results(input int t);
        n_errors += t;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `APB_MODE, 32'h0, 1'b0, 32'h3, 32'h0);
        bus(1'b0, 8'h08, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
        bus(1'b0, `APB_STATUS, 32'h0, 1'b0, 32'h7FF, 32'h400);
        tr(0, 1, `REG_IDENT, 0, 0, 3'h7, 0, 0);
        lreset();
        tr(0, 1, `REG_IDENT, 0, 0, 3'h1, 32'hFFFFFFFF, ID);
        tr(0, 1, `REG_CTRL_STAT, 1, 0, 3'h7, 0, 0);
        tr(0, 1, `REG_IDENT, 0, 0, 3'h7, 0, 0);
        lreset();
        tr(0, 1, `REG_IDENT, 0, 0, 3'h1, 32'hFFFFFFFF, ID);
        tr(0, 0, `REG_CTRL_STAT, 0, 32'h1, 3'h1, 0, 0);
        odet = 1'b1;
        hold = 1'b1;
        tr(1, 1, 2'h0, 0, 0, 3'h1, 0, 0);
        tr(1, 1, 2'h0, 0, 0, 3'h2, 0, 0);
        tr(1, 0, 2'h1, 0, $random(seed), 3'h4, 0, 0);
        tr(0, 1, `REG_CTRL_STAT, 0, 0, 3'h1, 32'hC3, 32'h03);
        tr(0, 0, `REG_ABORT, 0, 32'h11, 3'h1, 0, 0);
        hold = 1'b0;
        tr(0, 1, `REG_CTRL_STAT, 0, 0, 3'h1, 32'h03, 32'h01);
        tr(0, 0, `REG_CTRL_STAT, 0, 32'h0, 3'h1, 0, 0);
        odet = 1'b0;
        bus(1'b1, `APB_MODE, 32'h2, 1'b0, 32'h0, 32'h0);
        hold = 1'b1;
        tr(1, 0, 2'h1, 0, $random(seed), 3'h1, 0, 0);
        tr(1, 0, 2'h1, 0, $random(seed), 3'h1, 0, 0);
        tr(0, 0, `REG_SELECT, 0, 0, 3'h2, 0, 0);
        tr(1, 1, 2'h0, 0, 0, 3'h2, 0, 0);
        bus(1'b0, `APB_STATUS, 32'h0, 1'b0, 32'h300, 32'h300);
        tr(0, 1, `REG_IDENT, 0, 0, 3'h1, 32'hFFFFFFFF, ID);
        tr(0, 1, `REG_CTRL_STAT, 0, 0, 3'h1, 32'h80, 32'h80);
        tr(0, 0, `REG_SELECT, 0, 0, 3'h4, 0, 0);
        tr(0, 0, `REG_ABORT, 0, 32'h9, 3'h1, 0, 0);
        hold = 1'b0;
        bus(1'b1, `APB_MODE, 32'h1, 1'b0, 32'h0, 32'h0);
        tr(1, 0, 2'h1, 0, $random(seed), 3'h1, 0, 0);
        repeat (20) @(posedge clk);
        exp_q.push_back({3'h0, 32'h1, 32'h0});
        post({3'h0, 31'h0, last_wr});
        results(0);
    end
endmodule
`default_nettype wire
